// ---- cjh_map.svh ----
// Purpose: constants for the collision, jabber and heartbeat logic
// Assumes: 20 MHz system clock
// Notes:   times in their own unit, counts derived from the clock rate
`ifndef CJH_MAP_SVH
`define CJH_MAP_SVH
`define CLK_HZ              20000000
`define OSC_HZ              10000000
`define JABBER_MS           20
`define JABBER_CYC          ((`JABBER_MS * (`CLK_HZ / 1000)))
`define UNJAB_MS            500
`define UNJAB_CYC           ((`UNJAB_MS * (`CLK_HZ / 1000)))
`define HB_DELAY_NS         1100
`define HB_DELAY_CYC        ((`HB_DELAY_NS * (`CLK_HZ / 1000000)) / 1000)
`define HB_WIDTH_NS         1000
`define HB_WIDTH_CYC        ((`HB_WIDTH_NS * (`CLK_HZ / 1000000)) / 1000)
`define BIT_NS              100
`define EOT_NS              (2 * `BIT_NS)
`define EOT_CYC             ((`EOT_NS * (`CLK_HZ / 1000000)) / 1000)
`define GLITCH_NS           20
`define GLITCH_CYC          (((`GLITCH_NS * (`CLK_HZ / 1000000)) + 999) / 1000)
`define OSC_HALF_CYC        (`CLK_HZ / (2 * `OSC_HZ))
`endif

// ---- cjh_pkg.sv ----
// Purpose: types for the collision, jabber and heartbeat logic
// Assumes: nothing
// Notes:   none
package cjh_pkg;
    typedef enum logic [1:0] {
        idle_st   = 2'b00,
        active_st = 2'b01,
        jabber_st = 2'b10,
        unjab_st  = 2'b11
    } tx_state_e;

    typedef struct packed {
        logic collision;
        logic jabber;
        logic heartbeat;
    } cause_s;
endpackage

// ---- collision_jabber_heartbeat.sv ----
// Purpose: collision indication, jabber cut-off and heartbeat timing
// Assumes: 20 MHz clock; inputs from pins are digital levels; oscillator
//          is modelled as a 10 MHz toggle derived from the clock
// Notes:   long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`include "cjh_map.svh"
module collision_jabber_heartbeat
    import cjh_pkg::*;
#(
    parameter int JABBER_CYC = `JABBER_CYC,
    parameter int UNJAB_CYC  = `UNJAB_CYC
) (
    input  wire logic clock_in,
    input  wire logic rst_in,
    input  wire logic tx_data_in,
    input  wire logic tx_squelch_ok_in,
    input  wire logic collision_level_in,
    input  wire logic heartbeat_strap_in,
    output logic      cable_transmit_output_out,
    output logic      cable_transmit_enable_out,
    output logic      collision_indication_pos_out,
    output logic      collision_indication_neg_out,
    output cause_s    cause_out
);
    localparam int CW = 25;
    localparam logic [CW-1:0] JAB_LIM   = CW'(JABBER_CYC);
    localparam logic [CW-1:0] UNJAB_LIM = CW'(UNJAB_CYC);
    localparam logic [7:0] GLITCH_LIM = 8'(`GLITCH_CYC);
    localparam logic [7:0] EOT_LIM    = 8'(`EOT_CYC);
    localparam logic [7:0] HB_D_LIM   = 8'(`HB_DELAY_CYC);
    localparam logic [7:0] HB_W_LIM   = 8'(`HB_WIDTH_CYC);

    // two-stage synchronisers for pin inputs
    logic [1:0] s_tx, s_sq, s_col, s_hb;
    logic [1:0] next_s_tx, next_s_sq, next_s_col, next_s_hb;
    logic tx_q, tx_ok, col_q, hb_en;
    logic tx_prev, next_tx_prev;
    logic [7:0] width_cnt, next_width_cnt;
    logic [7:0] eot_cnt, next_eot_cnt;
    logic valid, next_valid;
    tx_state_e state, next_state;
    logic [CW-1:0] tcnt, next_tcnt;
    logic [7:0] hb_cnt, next_hb_cnt;
    logic hb_wait, next_hb_wait;
    logic hb_win, next_hb_win;
    logic osc, next_osc;
    logic coll_en;
    logic next_tx_line, next_txe, next_cdp, next_cdn;
    logic tx_line, txe, cdp, cdn;
    cause_s next_cause, cause;

    assign tx_q  = s_tx[1];
    assign tx_ok = s_sq[1];
    assign col_q = s_col[1];
    assign hb_en = s_hb[1];

    always_comb begin
        next_s_tx  = {s_tx[0], tx_data_in};
        next_s_sq  = {s_sq[0], tx_squelch_ok_in};
        next_s_col = {s_col[0], collision_level_in};
        next_s_hb  = {s_hb[0], heartbeat_strap_in};
        next_tx_prev = tx_q;
        next_width_cnt = width_cnt;
        next_eot_cnt = eot_cnt;
        next_valid = valid;
        // run length of the current level; a fresh level counts as one sample,
        // so every sampled change of level qualifies once, and so does any spike that a sample catches
        if (!tx_ok) begin
            next_width_cnt = 8'h00;
        end else if (tx_q != tx_prev) begin
            next_width_cnt = 8'h01;
        end else if (width_cnt != 8'hff) begin
            next_width_cnt = width_cnt + 8'h01;
        end
        if (tx_ok && width_cnt == GLITCH_LIM) begin
            next_valid   = 1'b1;
            next_eot_cnt = 8'h00;
        end else if (valid) begin
            if (eot_cnt >= EOT_LIM) begin
                next_valid = 1'b0;
            end else begin
                next_eot_cnt = eot_cnt + 8'h01;
            end
        end
    end

    always_comb begin
        next_state = state;
        next_tcnt  = tcnt;
        case (state)
            idle_st: begin
                next_tcnt = '0;
                if (valid) begin
                    next_state = active_st;
                end
            end
            active_st: begin
                next_tcnt = tcnt + CW'(1);
                if (!valid) begin
                    next_state = idle_st;
                end else if (tcnt >= JAB_LIM) begin
                    next_state = jabber_st;
                    next_tcnt  = '0;
                end
            end
            jabber_st: begin
                next_tcnt = '0;
                if (!valid) begin
                    next_state = unjab_st;
                end
            end
            unjab_st: begin
                // further data during this period restarts the wait
                next_tcnt = valid ? '0 : tcnt + CW'(1);
                if (!valid && tcnt >= UNJAB_LIM - CW'(1)) begin
                    next_state = idle_st;
                    next_tcnt  = '0;
                end
            end
            default: begin
                next_state = idle_st;
                next_tcnt  = '0;
            end
        endcase
    end

    always_comb begin
        next_hb_cnt  = hb_cnt;
        next_hb_wait = hb_wait;
        next_hb_win  = hb_win;
        if (state == active_st && !valid) begin
            next_hb_wait = hb_en;
            next_hb_win  = 1'b0;
            next_hb_cnt  = 8'h00;
        end else if (hb_wait) begin
            next_hb_cnt = hb_cnt + 8'h01;
            if (hb_cnt >= HB_D_LIM - 8'h01) begin
                next_hb_wait = 1'b0;
                next_hb_win  = 1'b1;
                next_hb_cnt  = 8'h00;
            end
        end else if (hb_win) begin
            next_hb_cnt = hb_cnt + 8'h01;
            if (hb_cnt >= HB_W_LIM - 8'h01) begin
                next_hb_win = 1'b0;
                next_hb_cnt = 8'h00;
            end
        end
    end

    always_comb begin
        next_cause.collision = col_q;
        next_cause.jabber    = (state == jabber_st) || (state == unjab_st);
        next_cause.heartbeat = hb_win;
        coll_en = cause.collision | cause.jabber | cause.heartbeat;
        next_osc = (`OSC_HALF_CYC == 1) ? ~osc : osc;
        next_cdp = coll_en ? osc : 1'b0;
        next_cdn = coll_en ? ~osc : 1'b0;
        next_txe = valid && tx_ok && !next_cause.jabber;
        next_tx_line = next_txe ? tx_q : 1'b0;
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            s_tx <= 2'h0; s_sq <= 2'h0; s_col <= 2'h0; s_hb <= 2'h0;
            tx_prev <= 1'b0;
            width_cnt <= 8'h00;
            eot_cnt <= 8'h00;
            valid <= 1'b0;
            state <= idle_st;
            tcnt <= '0;
            hb_cnt <= 8'h00;
            hb_wait <= 1'b0;
            hb_win <= 1'b0;
            osc <= 1'b0;
            cause <= '0;
            tx_line <= 1'b0;
            txe <= 1'b0;
            cdp <= 1'b0;
            cdn <= 1'b0;
        end else begin
            s_tx <= next_s_tx; s_sq <= next_s_sq; s_col <= next_s_col; s_hb <= next_s_hb;
            tx_prev <= next_tx_prev;
            width_cnt <= next_width_cnt;
            eot_cnt <= next_eot_cnt;
            valid <= next_valid;
            state <= next_state;
            tcnt <= next_tcnt;
            hb_cnt <= next_hb_cnt;
            hb_wait <= next_hb_wait;
            hb_win <= next_hb_win;
            osc <= next_osc;
            cause <= next_cause;
            tx_line <= next_tx_line;
            txe <= next_txe;
            cdp <= next_cdp;
            cdn <= next_cdn;
        end
    end

    assign cable_transmit_output_out    = tx_line;
    assign cable_transmit_enable_out    = txe;
    assign collision_indication_pos_out = cdp;
    assign collision_indication_neg_out = cdn;
    assign cause_out                    = cause;

    idle_zero_a: assert property (@(posedge clock_in) disable iff (rst_in)
        !coll_en |=> (!cdp && !cdn)) else $error("collision pair not quiet");
    osc_toggle_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (coll_en && $past(coll_en)) |=> (cdp != $past(cdp))) else $error("collision pair not toggling");
    cause_or_a: assert property (@(posedge clock_in) disable iff (rst_in)
        cause.jabber |=> (cdp || cdn)) else $error("jabber not signalled");
    col_follow_a: assert property (@(posedge clock_in) disable iff (rst_in)
        col_q |=> cause.collision) else $error("collision level not followed");
    jab_cut_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (state == jabber_st) |=> !txe) else $error("transmitter on in jabber");
    jab_start_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (state == idle_st && valid) |=> (state == active_st)) else $error("jabber timer not started");
    unjab_end_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (state == unjab_st && !valid && tcnt == UNJAB_LIM - CW'(1)) |=> (state == idle_st))
        else $error("jabber latch not released");
    hb_strap_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (state == active_st && !valid && !hb_en) |=> !hb_wait) else $error("heartbeat not suppressed");
    hb_delay_a: assert property (@(posedge clock_in) disable iff (rst_in)
        $rose(hb_wait) |-> !hb_win ##22 hb_win) else $error("heartbeat delay wrong");
    hb_excl_a: assert property (@(posedge clock_in) disable iff (rst_in)
        hb_wait |-> !hb_win) else $error("heartbeat window during delay");
    squelch_a: assert property (@(posedge clock_in) disable iff (rst_in)
        !tx_ok |=> !txe) else $error("unqualified data transmitted");
    eot_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (valid && eot_cnt >= EOT_LIM && !(tx_ok && width_cnt == GLITCH_LIM)) |=> !valid)
        else $error("end of transmission missed");

    hb_seen_c: cover property (@(posedge clock_in) disable iff (rst_in) $rose(hb_win));
    jab_seen_c: cover property (@(posedge clock_in) disable iff (rst_in) state == jabber_st);
    col_seen_c: cover property (@(posedge clock_in) disable iff (rst_in) $rose(cause.collision));
endmodule // collision_jabber_heartbeat

// ---- enc_model.sv ----
// Purpose: encoder side model driving the transmit pair
// Assumes: one half bit per clock, driven at the falling edge
// Notes:   line rests low outside frames
`timescale 1ns/1ps
module enc_model (
    input  wire logic clock_in,
    input  wire logic run_in,
    input  wire logic bit_in,
    input  wire logic squelch_en_in,
    input  wire logic jabber_in,
    output logic      tx_data_out,
    output logic      squelch_ok_out
);
    logic half = 1'b0;
    logic cur  = 1'b0;
    logic live = 1'b0;
    // no new frame starts while the device is still cut off
    always @(negedge clock_in) begin
        if (run_in && (live || !jabber_in)) begin
            live <= 1'b1;
            half <= ~half;
            squelch_ok_out <= squelch_en_in;
            // one-clock halves stay well above the noise width
            if (!half) begin
                cur <= bit_in;
                tx_data_out <= ~bit_in;
            end else begin
                tx_data_out <= cur;
            end
        end else begin
            // frame ends by going quiet
            live <= 1'b0;
            half <= 1'b0;
            tx_data_out <= 1'b0;
            squelch_ok_out <= 1'b0;
        end
    end
endmodule // enc_model

// ---- test_collision_jabber_heartbeat.sv ----
// Purpose: self-checking bench for collision, jabber and heartbeat logic
// Assumes: shortened jabber and release counts
// Notes:   stimulus at the falling edge, random bits from a fixed seed
`timescale 1ns/1ps
`include "cjh_map.svh"
module test_collision_jabber_heartbeat import cjh_pkg::*;;
    localparam int JAB = 200;
    localparam int UNJ = 300;
    logic        clock_in, rst_in, tx_data_in, tx_squelch_ok_in, collision_level_in, heartbeat_strap_in;
    logic        run, bit_v, sq_en, tx_out, tx_en, coll_p, coll_n;
    cause_s      cause;
    int          err_total = 0;
    int          n_checks = 0;
    logic [31:0] rng = 32'h0001199c;
    logic [31:0] r;
    collision_jabber_heartbeat #(.JABBER_CYC(JAB), .UNJAB_CYC(UNJ)) u_dut (.clock_in(clock_in),
        .rst_in(rst_in), .tx_data_in(tx_data_in), .tx_squelch_ok_in(tx_squelch_ok_in),
        .collision_level_in(collision_level_in), .heartbeat_strap_in(heartbeat_strap_in),
        .cable_transmit_output_out(tx_out), .cable_transmit_enable_out(tx_en),
        .collision_indication_pos_out(coll_p), .collision_indication_neg_out(coll_n), .cause_out(cause));
    enc_model u_enc (.clock_in(clock_in), .run_in(run), .bit_in(bit_v), .squelch_en_in(sq_en),
        .jabber_in(cause.jabber), .tx_data_out(tx_data_in), .squelch_ok_out(tx_squelch_ok_in));
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
            err_total++;
        end
    endtask
    task automatic end_sim();
        if (err_total == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task automatic wait_cause(input int b, input logic v, input int lim, output int k);
        k = 0;
        while (cause[b] !== v) begin
            if (k == lim) begin
                err_total++;
                end_sim();
            end
            cyc(1);
            k++;
        end
    endtask
    function automatic int hb_expect(input logic strap, input logic sq);
        return (strap && sq) ? `HB_WIDTH_CYC : 0;
    endfunction
    task automatic coll_test();
        int   k;
        logic prev;
        collision_level_in <= 1'b1;
        wait_cause(2, 1'b1, 10, k);
        check("coll_latency", k <= 4, 1);
        cyc(1);
        prev = coll_p;
        repeat (6) begin
            cyc(1);
            check("coll_toggle", coll_p, !prev);
            check("coll_pair", coll_n, !coll_p);
            prev = coll_p;
        end
        collision_level_in <= 1'b0;
        wait_cause(2, 1'b0, 10, k);
        cyc(2);
        check("coll_idle", {coll_p, coll_n}, 0);
    endtask
    task automatic frame(input int nbits, input logic strap, input logic sq);
        int   i, j, k, hb, first;
        logic h1, h2;
        heartbeat_strap_in <= strap;
        sq_en <= sq;
        run <= 1'b1;
        h1 = 1'b0;
        h2 = 1'b0;
        for (i = 0; i < nbits; i++) begin
            r = xs();
            bit_v <= r[0];
            // line level two falling edges back reaches the cable output now
            for (j = 0; j < 2; j++) begin
                cyc(1);
                if (i >= 6 && i < 90) check("tx_data", tx_out, sq ? h2 : 1'b0);
                h2 = h1;
                h1 = tx_data_in;
            end
            if (i == 6) check("tx_enable", tx_en, sq);
        end
        run <= 1'b0;
        if (nbits * 2 > JAB + 20) begin
            check("jabber_set", {cause.jabber, tx_en}, 2'h2);
            wait_cause(1, 1'b0, UNJ + 60, k);
            check("unjab_wait", k >= UNJ && k <= UNJ + 20, 1);
            cyc(80);
        end else begin
            hb = 0;
            first = 0;
            for (i = 0; i < 70; i++) begin
                cyc(1);
                if (cause.heartbeat === 1'b1) begin
                    if (hb == 0) first = i;
                    hb++;
                end
            end
            check("hb_width", hb, hb_expect(strap, sq));
            check("hb_delay", hb == 0 || (first > `HB_DELAY_CYC && first < `HB_DELAY_CYC + 18), 1);
            check("coll_after", {coll_p, coll_n}, 0);
        end
    endtask
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    initial begin
        repeat (100000) @(posedge clock_in);
        err_total++;
        end_sim();
    end
    initial begin
        rst_in = 1'b1;
        collision_level_in = 1'b0;
        heartbeat_strap_in = 1'b1;
        run = 1'b0;
        bit_v = 1'b0;
        sq_en = 1'b0;
        cyc(8);
        rst_in <= 1'b0;
        cyc(1);
        check("reset_out", {coll_p, coll_n, tx_en, tx_out, cause}, 0);
        cyc(4);
        coll_test();
        for (int m = 0; m < 8; m++) begin
            r = xs();
            frame(8 + int'(r[4:0]), m[0], m[1]);
        end
        frame(JAB / 2 + 20, 1'b1, 1'b1);
        frame(12, 1'b1, 1'b1);
        end_sim();
    end
endmodule // test_collision_jabber_heartbeat
